// *** logic/lowpower_rtc_backup.sv ***
// Calendar clock with alarms, wakeup timer, tamper, timestamp and backup storage
`timescale 1ns/1ps
`include "rtc_regs.svh"
module lowpower_rtc_backup #(
  parameter int NUM_BKP = 5
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        xtal_clk,
  input  wire logic        ext_clk,
  input  wire logic        lrc_clk,
  input  wire logic        hse_clk,
  input  wire logic        ref_in,
  input  wire logic [1:0]  tamper_in,
  input  wire logic        ts_in,
  output logic [31:0]      rdata,
  output logic             irq,
  output logic             wake
);
  import rtc_pkg::*;

  logic [7:0]  pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [21:0] ctrl_reg;
  logic [22:0] pre_reg;
  logic [8:0]  calm_reg;
  logic [19:0] cal_cnt_reg;
  logic [6:0]  apre_reg;
  logic [14:0] ss_reg;
  logic [5:0]  ref_cnt_reg;
  time_s       time_reg, time_next, ts_time_reg;
  date_s       date_reg, date_next, ts_date_reg;
  logic        day_c, tick_d_reg;
  logic [31:0] alm_reg [2];
  logic [15:0] wut_rld_reg, wut_cnt_reg;
  logic [3:0]  tamp_reg;
  logic [1:0]  act_d_reg;
  logic [3:0]  flt_cnt_reg [2];
  evt_t        stat_reg, msk_reg, stat_next;
  logic [31:0] bkp_mem [NUM_BKP];
  logic [31:0] rdata_reg, rd_mux;
  logic        irq_reg, wake_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Register write decode
  wire w_time = wr && addr == `A_TIME;
  wire w_date = wr && addr == `A_DATE;
  wire w_ctrl = wr && addr == `A_CTRL;
  wire w_pre  = wr && addr == `A_PRE;
  wire w_sh   = wr && addr == `A_SHIFT;
  wire w_cal  = wr && addr == `A_CAL;
  wire w_wut  = wr && addr == `A_WUT;
  wire w_alma = wr && addr == `A_ALMA;
  wire w_almb = wr && addr == `A_ALMB;
  wire w_tamp = wr && addr == `A_TAMP;
  wire w_stat = wr && addr == `A_STAT;
  wire w_mask = wr && addr == `A_MASK;
  wire bk_hit = addr[7:5] == `A_BKP && addr[4:2] < 3'(NUM_BKP) && addr[1:0] == 2'h0;
  wire w_bkp  = wr && bk_hit;

  // Control fields
  wire       fmt12    = ctrl_reg[`CT_FMT12];
  wire       ref_en   = ctrl_reg[`CT_REFEN];
  wire       wut_en   = ctrl_reg[`CT_WUTE];
  wire [5:0] wake_msk = ctrl_reg[`CT_WAKE +: 6];
  clk_src_e  src_sel;
  assign src_sel = clk_src_e'(ctrl_reg[`CT_SRC +: 2]);
  wire [6:0]  apre_val = pre_reg[22:16];
  wire [14:0] spre_val = pre_reg[14:0];

  // Every pin is foreign to clk, so two stages before anything looks at it
  wire [7:0] pin_raw = {ts_in, tamper_in, ref_in, hse_clk, lrc_clk, ext_clk, xtal_clk};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
      pin_s3_reg <= 8'h00;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  wire [7:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire [7:0] pin_fall = ~pin_s2_reg & pin_s3_reg;

  // Source select; the high-speed clock must arrive pre-divided below clk/2
  wire src_edge = pin_rise[src_sel];

  // Calibration swallows the first calm pulses of each 2^20 pulse window
  wire cal_skip  = cal_cnt_reg < {11'h000, calm_reg};
  wire rtc_pulse = src_edge && !cal_skip;

  // Prescaler chain: async divider then subsecond down counter
  wire apre_tick = rtc_pulse && apre_reg == 7'h00;
  wire ss_wrap   = apre_tick && ss_reg == 15'h0000;
  wire [5:0] ref_lim = ctrl_reg[`CT_REF60] ? `REF60 : `REF50;
  wire ref_sec   = ref_en && pin_rise[4] && ref_cnt_reg == ref_lim;
  wire add1s     = w_sh && wdata[`SH_ADD1S];
  wire sec_tick  = (ref_en ? ref_sec : ss_wrap) || add1s;

  // Shift delays the clock by adding pulses to the subsecond count
  wire [15:0] ss_add   = {1'b0, ss_reg} + {1'b0, wdata[14:0]};
  wire [15:0] ss_over  = ss_add - {1'b0, spre_val} - 16'h0001;
  wire [14:0] ss_shift = ss_add > {1'b0, spre_val} ? ss_over[14:0] : ss_add[14:0];

  // Prescaler and calibration window counters
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      apre_reg    <= `RST_APRE;
      ss_reg      <= `RST_SPRE;
      cal_cnt_reg <= 20'h00000;
      ref_cnt_reg <= 6'h00;
    end else begin
      if (src_edge) cal_cnt_reg <= cal_cnt_reg + 20'h00001;
      if (ref_en && pin_rise[4]) ref_cnt_reg <= ref_sec ? 6'h00 : ref_cnt_reg + 6'h01;
      if (w_pre || ref_sec) begin
        apre_reg <= w_pre ? wdata[22:16] : apre_val;
        ss_reg   <= w_pre ? wdata[14:0] : spre_val;
      end else if (w_sh) begin
        ss_reg <= ss_shift;
      end else if (rtc_pulse) begin
        apre_reg <= apre_tick ? apre_val : apre_reg - 7'h01;
        if (apre_tick) ss_reg <= ss_wrap ? spre_val : ss_reg - 15'h0001;
      end
    end
  end

  // BCD step: wraps from last to first with a carry
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                         input logic [7:0] first);
    if (v == last) return {1'b1, first};
    if (v[3:0] == 4'h9) return {1'b0, v[7:4] + 4'h1, 4'h0};
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // Month length with leap years on BCD years divisible by four
  function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mo)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : month_len

  wire [8:0] sec_i  = bcd_inc(time_reg.sec, 8'h59, 8'h00);
  wire [8:0] min_i  = bcd_inc(time_reg.min, 8'h59, 8'h00);
  wire [8:0] hr24_i = bcd_inc(time_reg.hour, 8'h23, 8'h00);
  wire [8:0] hr12_i = bcd_inc(time_reg.hour, 8'h12, 8'h01);
  wire [8:0] date_i = bcd_inc(date_reg.date, month_len(date_reg.month, date_reg.year), 8'h01);
  wire [8:0] mon_i  = bcd_inc(date_reg.month, 8'h12, 8'h01);
  wire [8:0] yr_i   = bcd_inc(date_reg.year, 8'h99, 8'h00);

  // Next calendar value, one second later
  always_comb begin
    time_next = time_reg;
    date_next = date_reg;
    day_c     = 1'b0;
    time_next.sec = sec_i[7:0];
    if (sec_i[8]) begin
      time_next.min = min_i[7:0];
      if (min_i[8]) begin
        if (!fmt12) begin
          time_next.hour = hr24_i[7:0];
          day_c          = hr24_i[8];
        end else begin
          time_next.hour = hr12_i[7:0];
          if (time_reg.hour == 8'h11) begin
            time_next.pm = ~time_reg.pm;
            day_c        = time_reg.pm;
          end
        end
      end
    end
    if (day_c) begin
      date_next.wday = date_reg.wday == 3'h7 ? 3'h1 : date_reg.wday + 3'h1;
      date_next.date = date_i[7:0];
      if (date_i[8]) begin
        date_next.month = mon_i[7:0];
        if (mon_i[8]) date_next.year = yr_i[7:0];
      end
    end
  end

  // Calendar registers; a software write wins over a coinciding tick.
  // Nothing here looks at a power mode, so the calendar runs in all of them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_reg   <= '0;
      date_reg   <= date_s'(`RST_DATE);
      tick_d_reg <= 1'b0;
    end else begin
      tick_d_reg <= sec_tick;
      if (w_time) time_reg <= time_s'(wdata[24:0]);
      else if (sec_tick) time_reg <= time_next;
      if (w_date) date_reg <= date_s'(wdata[26:0]);
      else if (sec_tick) date_reg <= date_next;
    end
  end

  sec_roll_a: assert property (sec_tick && !w_time && time_reg.sec == 8'h59 |=>
    time_reg.sec == 8'h00 && time_reg.min != $past(time_reg.min))
    else $error("seconds did not roll into minutes");
  hour_pm_a: assert property (sec_tick && !w_time && fmt12 && time_reg.hour == 8'h11 &&
    time_reg.min == 8'h59 && time_reg.sec == 8'h59 |=>
    time_reg.hour == 8'h12 && time_reg.pm != $past(time_reg.pm))
    else $error("12-hour wrap wrong");
  month_end_a: assert property (sec_tick && day_c && !w_date &&
    date_reg.month == 8'h04 && date_reg.date == 8'h30 |=>
    date_reg.date == 8'h01 && date_reg.month == 8'h05)
    else $error("30-day month rollover wrong");
  leap_feb_a: assert property (sec_tick && day_c && !w_date && date_reg.month == 8'h02 &&
    date_reg.date == 8'h28 && date_reg.year == 8'h24 |=> date_reg.date == 8'h29)
    else $error("leap February skipped the 29th");

  // Alarm compare on the cycle after the calendar moved
  function automatic logic alm_match(input logic [31:0] a, input time_s t, input date_s d);
    return (a[7] || a[6:0] == t.sec[6:0]) && (a[15] || a[14:8] == t.min[6:0]) &&
           (a[23] || a[21:16] == t.hour[5:0]) && (a[31] || a[29:24] == d.date[5:0]);
  endfunction : alm_match
  wire hit_a = tick_d_reg && ctrl_reg[`CT_ALAE] && alm_match(alm_reg[0], time_reg, date_reg);
  wire hit_b = tick_d_reg && ctrl_reg[`CT_ALBE] && alm_match(alm_reg[1], time_reg, date_reg);

  // Wakeup timer runs from the divided clock or the second tick
  wire wut_clk = ctrl_reg[`CT_WSEL] ? sec_tick : apre_tick;
  wire wut_ev  = wut_en && wut_clk && wut_cnt_reg == 16'h0000;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) wut_cnt_reg <= 16'hFFFF;
    else if (!wut_en) wut_cnt_reg <= wut_rld_reg;
    else if (wut_clk) wut_cnt_reg <= wut_ev ? wut_rld_reg : wut_cnt_reg - 16'h0001;
  end

  // Tamper filters count stable active samples at the divided rate
  wire [1:0] tamp_act;
  wire [1:0] tamp_ev;
  for (genvar i = 0; i < 2; i++) begin : g_tamp
    wire [3:0] need = 4'h1 << tamp_reg[1:0];
    assign tamp_act[i] = pin_s2_reg[5+i] ~^ tamp_reg[2+i];
    assign tamp_ev[i]  = tamp_reg[1:0] == 2'h0 ? tamp_act[i] && !act_d_reg[i]
                       : tamp_act[i] && apre_tick && flt_cnt_reg[i] == need - 4'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_d_reg      <= 2'h0;
      flt_cnt_reg[0] <= 4'h0;
      flt_cnt_reg[1] <= 4'h0;
    end else begin
      act_d_reg <= tamp_act;
      for (int i = 0; i < 2; i++) begin
        if (!tamp_act[i]) flt_cnt_reg[i] <= 4'h0;
        else if (apre_tick && flt_cnt_reg[i] != 4'hF) flt_cnt_reg[i] <= flt_cnt_reg[i] + 4'h1;
      end
    end
  end

  // Timestamp from its pin edge or, if chosen, from any tamper event
  wire ts_ev   = ctrl_reg[`CT_TSPOL] ? pin_rise[7] : pin_fall[7];
  wire ts_trig = ts_ev || (ctrl_reg[`CT_TSTMP] && |tamp_ev);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ts_time_reg <= '0;
      ts_date_reg <= '0;
    end else if (ts_trig) begin
      ts_time_reg <= time_reg;
      ts_date_reg <= date_reg;
    end
  end

  // Sticky flags: a new event wins over a write-one clear in the same cycle
  wire evt_t evt = {ts_trig, tamp_ev, wut_ev, hit_b, hit_a};
  assign stat_next = (stat_reg & ~(w_stat ? wdata[5:0] : 6'h00)) | evt;
  // Mask as it stands after this edge, so irq never lags a mask write by a cycle
  wire [5:0] msk_next = w_mask ? wdata[5:0] : msk_reg;

  // Configuration registers and flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg    <= 22'h000000;
      pre_reg     <= {`RST_APRE, 1'b0, `RST_SPRE};
      calm_reg    <= 9'h000;
      wut_rld_reg <= 16'hFFFF;
      alm_reg[0]  <= 32'h00000000;
      alm_reg[1]  <= 32'h00000000;
      tamp_reg    <= 4'hC;
      stat_reg    <= 6'h00;
      msk_reg     <= 6'h00;
      irq_reg     <= 1'b0;
      wake_reg    <= 1'b0;
    end else begin
      if (w_ctrl) ctrl_reg <= wdata[21:0];
      if (w_pre) pre_reg <= {wdata[22:16], 1'b0, wdata[14:0]};
      if (w_cal) calm_reg <= wdata[8:0];
      if (w_wut) wut_rld_reg <= wdata[15:0];
      if (w_alma) alm_reg[0] <= wdata;
      if (w_almb) alm_reg[1] <= wdata;
      if (w_tamp) tamp_reg <= wdata[3:0];
      if (w_mask) msk_reg <= wdata[5:0];
      stat_reg <= stat_next;
      irq_reg  <= |(stat_next & msk_next);
      wake_reg <= |(stat_next & wake_msk);
    end
  end

  // Backup words have no reset on purpose so a system reset keeps them
  always_ff @(posedge clk) begin
    if (w_bkp) bkp_mem[addr[4:2]] <= wdata;
  end

  alarm_flag_a: assert property (hit_a |=> stat_reg[0])
    else $error("alarm A match left no flag");
  wut_reload_a: assert property (wut_ev && !w_wut |=>
    stat_reg[2] && wut_cnt_reg == $past(wut_rld_reg))
    else $error("wakeup expiry did not flag and reload");
  shift_sec_a: assert property (w_sh && wdata[`SH_ADD1S] && !w_time |=>
    time_reg != $past(time_reg))
    else $error("add-one-second had no effect");
  ref_align_a: assert property (ref_sec && !w_pre |=> ss_reg == $past(spre_val))
    else $error("reference second did not realign subseconds");
  cal_mask_a: assert property (src_edge && cal_skip && !w_pre && !ref_sec |=>
    apre_reg == $past(apre_reg))
    else $error("calibration pulse was not swallowed");
  tamp_filter_a: assert property (tamp_ev[0] && tamp_reg[1:0] != 2'h0 |->
    tamp_act[0] && $past(tamp_act[0]) && flt_cnt_reg[0] != 4'h0)
    else $error("tamper event without stable input");
  tamp_wake_a: assert property (tamp_ev[0] && wake_msk[3] |=> wake_reg)
    else $error("tamper did not raise wake");
  ts_capture_a: assert property (ts_trig |=> ts_time_reg == $past(time_reg) &&
    ts_date_reg == $past(date_reg))
    else $error("timestamp did not capture calendar");
  ts_flag_a: assert property (ts_trig ##1 wake_msk[5] |-> stat_reg[5] && wake_reg)
    else $error("timestamp did not flag or wake");
  bkp_hold_a: assert property (!w_bkp |=> $stable(bkp_mem[0]))
    else $error("backup word changed without a write");
  irq_level_a: assert property (irq_reg == |(stat_reg & msk_reg))
    else $error("interrupt output disagrees with flags");

  alarm_seen_c: cover property (hit_a ##1 irq_reg);
  wut_seen_c: cover property (wut_ev);
  tamp_ts_c: cover property (tamp_ev[1] && ts_trig);
  ref_seen_c: cover property (ref_sec);

  // Read selection; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr)
      `A_TIME:   rd_mux = {7'h00, time_reg};
      `A_DATE:   rd_mux = {5'h00, date_reg};
      `A_CTRL:   rd_mux = {10'h000, ctrl_reg};
      `A_PRE:    rd_mux = {9'h000, pre_reg};
      `A_SUBSEC: rd_mux = {17'h00000, ss_reg};
      `A_CAL:    rd_mux = {23'h000000, calm_reg};
      `A_WUT:    rd_mux = {wut_cnt_reg, wut_rld_reg};
      `A_ALMA:   rd_mux = alm_reg[0];
      `A_ALMB:   rd_mux = alm_reg[1];
      `A_TAMP:   rd_mux = {28'h0000000, tamp_reg};
      `A_TSTIME: rd_mux = {7'h00, ts_time_reg};
      `A_TSDATE: rd_mux = {5'h00, ts_date_reg};
      `A_STAT:   rd_mux = {26'h0000000, stat_reg};
      `A_MASK:   rd_mux = {26'h0000000, msk_reg};
      default:   rd_mux = bk_hit ? bkp_mem[addr[4:2]] : 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata_reg <= 32'h00000000;
    else rdata_reg <= rd ? rd_mux : 32'h00000000;
  end

  assign rdata = rdata_reg;
  assign irq   = irq_reg;
  assign wake  = wake_reg;
endmodule : lowpower_rtc_backup

// *** logic/rtc_regs.svh ***
// Register offsets, field positions, reset values and counts of the calendar clock
// Operation
// - Keep binary subseconds and BCD time, weekday, date, month, year; 12 or 24 hour
// - Roll the date over on 28, 29 in leap years, 30 and 31 day months
// - Two programmable calendar alarms, each able to wake the system
// - Periodic wakeup timer with selectable resolution and period, able to wake
// - Shift running time by 1 to 32767 clock pulses while counting
// - Optional 50 or 60 Hz reference keeps the seconds aligned
// - Digital calibration in steps of one pulse per 2^20 (about 0.954 ppm) against crystal error
// - Two tamper inputs, each behind a programmable filter
// - A tamper event can wake the system
// - Copy calendar into timestamp storage on timestamp pin or tamper event
// - A timestamp event can wake the system
// - Five 32-bit backup registers, 20 bytes of storage
// - Backup registers untouched by system reset and standby wakeup
// - Calendar and backup keep working in every power mode
// - Counting clock from crystal, external, low-power RC or high-speed clock
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
`define A_TIME   8'h00
`define A_DATE   8'h04
`define A_CTRL   8'h08
`define A_PRE    8'h0C
`define A_SUBSEC 8'h10
`define A_SHIFT  8'h14
`define A_CAL    8'h18
`define A_WUT    8'h1C
`define A_ALMA   8'h20
`define A_ALMB   8'h24
`define A_TAMP   8'h28
`define A_TSTIME 8'h2C
`define A_TSDATE 8'h30
`define A_STAT   8'h34
`define A_MASK   8'h38
`define A_BKP    3'h2
`define CT_FMT12 0
`define CT_WSEL  1
`define CT_REFEN 2
`define CT_REF60 3
`define CT_TSTMP 4
`define CT_ALAE  5
`define CT_ALBE  6
`define CT_WUTE  7
`define CT_SRC   8
`define CT_TSPOL 10
`define CT_WAKE  16
`define SH_ADD1S 31
`define RST_APRE 7'h7F
`define RST_SPRE 15'h00FF
`define RST_DATE 27'h0010101
`define REF50    6'h31
`define REF60    6'h3B
`endif

// *** logic/rtc_pkg.sv ***
// Types shared by the calendar clock
package rtc_pkg;
  typedef struct packed {
    logic       pm;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } time_s;
  typedef struct packed {
    logic [7:0] year;
    logic [2:0] wday;
    logic [7:0] month;
    logic [7:0] date;
  } date_s;
  typedef enum logic [1:0] {
    SRC_XTAL = 2'h0,
    SRC_EXT  = 2'h1,
    SRC_LRC  = 2'h2,
    SRC_HSE  = 2'h3
  } clk_src_e;
  typedef logic [5:0] evt_t;
endpackage : rtc_pkg

// *** tb/pin_source.sv ***
// Far-side model: counting clock sources, mains reference, tamper and timestamp pins
`timescale 1ns/1ps
module pin_source (
  input  wire logic       clk,
  input  wire logic [3:0] src_run,
  input  wire logic       ref_run,
  input  wire logic [1:0] tamper_lvl,
  input  wire logic       ts_lvl,
  output logic      [3:0] src_clk,
  output logic            ref_clk,
  output logic      [1:0] tamper_pin,
  output logic            ts_pin
);
  logic [1:0] div_reg = 2'h0;
  logic [3:0] src_reg = 4'h0;
  logic       ref_reg = 1'b0;

  // Slow clocks toggle every 4 cycles, well under half the system rate; a stopped one stands
  always @(posedge clk) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) begin
      src_reg <= src_reg ^ src_run;
      ref_reg <= ref_reg ^ ref_run;
    end
  end
  assign src_clk = src_reg;
  assign ref_clk = ref_reg;

  // Pins are pushed by the bench's commands; the device sees them through its synchronisers
  assign tamper_pin = tamper_lvl;
  assign ts_pin     = ts_lvl;
endmodule : pin_source

// *** tb/tb_top.sv ***
// Self-checking bench for the calendar clock: registers, rollover, events, clock sources
`timescale 1ns/1ps
`include "rtc_regs.svh"
module tb_top;
  import rtc_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] t_in;
    logic [31:0] d_in;
    logic [31:0] t_out;
    logic [31:0] d_out;
  } roll_s;
  logic        clk        = 1'b0;
  logic        arst_n     = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic [31:0] wdata      = 32'h0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [3:0]  src_run    = 4'h0;
  logic        ref_run    = 1'b0;
  logic [1:0]  tamper_lvl = 2'h0;
  logic        ts_lvl     = 1'b0;
  logic [3:0]  src_clk;
  logic        ref_clk;
  logic [1:0]  tamper_pin;
  logic        ts_pin;
  logic [31:0] rdata;
  logic        irq;
  logic        wake;
  logic [31:0] v;
  int          miscompares = 0;
  int          checked     = 0;
  roll_s       rows [10];
  logic [7:0]  rst_a [8] = '{`A_TIME, `A_DATE, `A_PRE, `A_TAMP, `A_CTRL, `A_STAT, `A_MASK, 8'h3C};
  logic [31:0] rst_v [8] = '{32'h0, 32'h00010101, 32'h007F00FF, 32'hC, 32'h0, 32'h0, 32'h0, 32'h0};

  always #20 clk = ~clk;

  lowpower_rtc_backup #(.NUM_BKP(5)) lowpower_rtc_backup_i (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .xtal_clk(src_clk[0]), .ext_clk(src_clk[1]), .lrc_clk(src_clk[2]), .hse_clk(src_clk[3]),
    .ref_in(ref_clk), .tamper_in(tamper_pin), .ts_in(ts_pin),
    .rdata(rdata), .irq(irq), .wake(wake)
  );

  pin_source pin_source_i (
    .clk(clk), .src_run(src_run), .ref_run(ref_run), .tamper_lvl(tamper_lvl),
    .ts_lvl(ts_lvl), .src_clk(src_clk), .ref_clk(ref_clk), .tamper_pin(tamper_pin),
    .ts_pin(ts_pin)
  );

  // Packs year, weekday, month, date digits written as one hex word into the date layout
  function automatic logic [31:0] dt(input logic [27:0] x);
    return {5'h00, x[27:20], x[18:16], x[15:8], x[7:0]};
  endfunction : dt

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] val);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 val = rdata;
  endtask : rd_reg

  // Bounded wait for any masked bit; running out ends the run as a failure
  task automatic poll(input logic [7:0] a, input logic [31:0] m, output logic [31:0] val);
    int n;
    val = 32'h0;
    for (n = 0; n < 300 && (val & m) === 32'h0; n++) begin
      rd_reg(a, val);
    end
    if ((val & m) === 32'h0) begin
      miscompares++;
      $display("CHECK FAILED wait %h expected %h seen %h", a, m, val);
      finish_test();
    end
  endtask : poll

  // Immediate one-second step keeps calendar cases independent of the slow clocks
  task automatic tick();
    wr_reg(`A_SHIFT, 32'h80000000);
    repeat (2) @(posedge clk);
  endtask : tick

  task automatic pulse_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
  endtask : pulse_reset

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("CHECK FAILED run length expected end seen hang");
    finish_test();
  end

  initial begin
    rows[0] = '{32'h0, 32'h00235959, dt(28'h2330228), 32'h0, dt(28'h2340301)};
    rows[1] = '{32'h0, 32'h00235959, dt(28'h2430228), 32'h0, dt(28'h2440229)};
    rows[2] = '{32'h0, 32'h00235959, dt(28'h2440229), 32'h0, dt(28'h2450301)};
    rows[3] = '{32'h0, 32'h00235959, dt(28'h2350430), 32'h0, dt(28'h2360501)};
    rows[4] = '{32'h0, 32'h00235959, dt(28'h2370131), 32'h0, dt(28'h2310201)};
    rows[5] = '{32'h0, 32'h00235959, dt(28'h2361231), 32'h0, dt(28'h2470101)};
    rows[6] = '{32'h1, 32'h00115959, dt(28'h2310115), 32'h01120000, dt(28'h2310115)};
    rows[7] = '{32'h0, 32'h00125959, dt(28'h2310115), 32'h00130000, dt(28'h2310115)};
    rows[8] = '{32'h1, 32'h01115959, dt(28'h2310115), 32'h00120000, dt(28'h2320116)};
    rows[9] = '{32'h0, 32'h00005959, dt(28'h2320116), 32'h00010000, dt(28'h2320116)};
    pulse_reset();
    #1;
    chk("irq after reset", {31'h0, irq}, 32'h0);
    chk("rdata after reset", rdata, 32'h0);
    foreach (rst_a[i]) begin
      rd_reg(rst_a[i], v);
      chk("reset value", v, rst_v[i]);
    end
    // Backup words, an unmapped word and a misaligned address, then survival of reset
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h40 + 8'(4 * i), 32'hA5C30000 + 32'(i));
    end
    wr_reg(8'h60, 32'hFFFFFFFF);
    rd_reg(8'h60, v);
    chk("unmapped", v, 32'h0);
    rd_reg(8'h41, v);
    chk("misaligned", v, 32'h0);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        rd_reg(8'h40 + 8'(4 * i), v);
        chk("backup", v, 32'hA5C30000 + 32'(i));
      end
      pulse_reset();
    end
    foreach (rows[i]) begin
      wr_reg(`A_CTRL, rows[i].ctrl);
      wr_reg(`A_TIME, rows[i].t_in);
      wr_reg(`A_DATE, rows[i].d_in);
      tick();
      rd_reg(`A_TIME, v);
      chk("time", v, rows[i].t_out);
      rd_reg(`A_DATE, v);
      chk("date", v, rows[i].d_out);
    end
    // Both alarms: flag while masked, then irq, then clear by writing one
    for (int k = 0; k < 2; k++) begin
      wr_reg(`A_MASK, 32'h0);
      wr_reg(`A_CTRL, (32'h20 << k) | (32'h10000 << k));
      wr_reg(`A_ALMA + 8'(4 * k), 32'h80808000);
      wr_reg(`A_TIME, 32'h00000059);
      tick();
      poll(`A_STAT, 32'h1 << k, v);
      chk("alarm flag", v, 32'h1 << k);
      chk("masked irq", {31'h0, irq}, 32'h0);
      chk("alarm wake", {31'h0, wake}, 32'h1);
      wr_reg(`A_MASK, 32'h3F);
      rd_reg(`A_STAT, v);
      chk("irq", {31'h0, irq}, 32'h1);
      wr_reg(`A_STAT, 32'h1 << k);
      rd_reg(`A_STAT, v);
      chk("cleared flag", v, 32'h0);
      chk("cleared irq", {31'h0, irq}, 32'h0);
    end
    wr_reg(`A_WUT, 32'h1);
    wr_reg(`A_CTRL, 32'h00040082);
    repeat (3) tick();
    poll(`A_STAT, 32'h4, v);
    chk("wakeup wake", {31'h0, wake}, 32'h1);
    wr_reg(`A_CTRL, 32'h00180010);
    wr_reg(`A_STAT, 32'h3F);
    wr_reg(`A_TIME, 32'h00012345);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      tamper_lvl <= 2'h1 << k;
      poll(`A_STAT, 32'h8 << k, v);
      chk("tamper wake", {31'h0, wake}, 32'h1);
      poll(`A_STAT, 32'h20, v);
      rd_reg(`A_TSTIME, v);
      chk("tamper stamp", v, 32'h00012345);
      wr_reg(`A_STAT, 32'h3F);
      @(posedge clk);
      tamper_lvl <= 2'h0;
    end
    wr_reg(`A_CTRL, 32'h00200400);
    wr_reg(`A_TIME, 32'h00065432);
    @(posedge clk);
    ts_lvl <= 1'b1;
    poll(`A_STAT, 32'h20, v);
    chk("stamp wake", {31'h0, wake}, 32'h1);
    rd_reg(`A_TSTIME, v);
    chk("stamp time", v, 32'h00065432);
    rd_reg(`A_TSDATE, v);
    chk("stamp date", v, dt(28'h2320116));
    // Each counting source alone must carry the calendar one second forward
    wr_reg(`A_PRE, 32'h00010001);
    for (int s = 0; s < 4; s++) begin
      wr_reg(`A_CTRL, 32'(s) << `CT_SRC);
      wr_reg(`A_TIME, 32'h0);
      @(posedge clk);
      src_run <= 4'h1 << s;
      poll(`A_TIME, 32'hFFFFFFFF, v);
      chk("second from source", v, 32'h1);
      @(posedge clk);
      src_run <= 4'h0;
    end
    for (int r = 0; r < 2; r++) begin
      wr_reg(`A_CTRL, 32'h4 | (32'(r) << `CT_REF60));
      wr_reg(`A_TIME, 32'h0);
      @(posedge clk);
      ref_run <= 1'b1;
      poll(`A_TIME, 32'hFFFFFFFF, v);
      chk("second from reference", v, 32'h1);
      @(posedge clk);
      ref_run <= 1'b0;
    end
    // Swallowed pulses: about twelve pulses that would make three seconds must add none
    wr_reg(`A_CAL, 32'h1FF);
    wr_reg(`A_CTRL, 32'h0);
    wr_reg(`A_TIME, 32'h0);
    @(posedge clk);
    src_run <= 4'h1;
    repeat (100) @(posedge clk);
    rd_reg(`A_TIME, v);
    chk("swallowed pulses", v, 32'h0);
    src_run <= 4'h0;
    // Shift past the prescaler top wraps within the second: 0xFF plus 5 over 256 steps
    wr_reg(`A_CAL, 32'h0);
    wr_reg(`A_PRE, 32'h007F00FF);
    wr_reg(`A_SHIFT, 32'h5);
    rd_reg(`A_SUBSEC, v);
    chk("shifted subseconds", v, 32'h4);
    finish_test();
  end
endmodule : tb_top
